// ---- rtl/lbc_defs.svh ----
`ifndef LBC_DEFS_SVH
`define LBC_DEFS_SVH
// Contract
// - USB attached and not logging: indicator steadily lit.
// - USB data transfer in progress: indicator blinks continuously.
// - First host communication: several blinks, then steadily lit.
// - No USB and no logging session: indicator dark.
// - Logging disabled: indicator off, no samples recorded.
// - Power-up mode: indicator lit at power, one blink per sample.
// - Button mode: dark until one second hold, then lit, blink per sample.
// - Card full or removed while logging: 250 ms period blinking until reinserted.
// - First sample one second after indicator lights.
// - Button hold ends logging; indicator off confirms stop.
// - Samples buffered before card write; button stop flushes buffer.
// - Button ignored while USB attached and not logging.
// - No logging while USB attached; standalone supply only.
// - Cards up to 2 GB; formatted card required to log.
// - Samples stored on card as raw binary words.
// - Firmware revision 3 or later presents mass storage to host.
`define LBC_CLK_KHZ 20000
`define LBC_SEC_MS 1000
`define LBC_HOLD_MS 1000
`define LBC_FAULT_PERIOD_MS 250
`define LBC_PULSE_MS 50
`define LBC_DEB_MS 10
`define LBC_SEC_CYC (`LBC_CLK_KHZ * `LBC_SEC_MS)
`define LBC_HOLD_CYC (`LBC_CLK_KHZ * `LBC_HOLD_MS)
`define LBC_FAST_HALF_CYC (`LBC_CLK_KHZ * `LBC_FAULT_PERIOD_MS / 2)
`define LBC_PULSE_CYC (`LBC_CLK_KHZ * `LBC_PULSE_MS)
`define LBC_DEB_CYC (`LBC_CLK_KHZ * `LBC_DEB_MS)
`define LBC_INIT_TOGGLES 3'h6
`define LBC_CARD_MAX_MB 16'h0800
`define LBC_MSC_MIN_REV 3
`define LBC_FW_REV 3
`define LBC_BUF_DEPTH 16
`define LBC_SAMPLE_W 16
`define LBC_CNT_W 25
`endif

// ---- rtl/lbc_pkg.sv ----
package lbc_pkg;
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_PWRUP = 2'h1,
    MODE_BUTTON = 2'h2,
    MODE_TIMED = 2'h3
  } lbc_mode_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ARMED = 5'h02,
    ST_LOG = 5'h04,
    ST_FAULT = 5'h08,
    ST_FLUSH = 5'h10
  } lbc_state_t;
endpackage : lbc_pkg

// ---- rtl/lbc_debounce.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "lbc_defs.svh"
module lbc_debounce #(
  parameter int unsigned DEB_CYC = `LBC_DEB_CYC,
  parameter int unsigned CW = `LBC_CNT_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic btnPin,
  output logic btnLevel
);
  localparam logic [CW-1:0] DEB_LAST = CW'(DEB_CYC - 1);
  logic meta_reg, sync_reg, level_reg, level_next;
  logic [CW-1:0] cnt_reg, cnt_next;

  always_comb begin
    level_next = level_reg;
    cnt_next = '0;
    if (sync_reg != level_reg) begin
      if (cnt_reg == DEB_LAST) begin
        level_next = sync_reg;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      level_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      meta_reg <= btnPin;
      sync_reg <= meta_reg;
      level_reg <= level_next;
      cnt_reg <= cnt_next;
    end
  end

  assign btnLevel = level_reg;
endmodule : lbc_debounce
`default_nettype wire

// ---- rtl/lbc_sample_buf.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "lbc_defs.svh"
module lbc_sample_buf #(
  parameter int unsigned W = `LBC_SAMPLE_W,
  parameter int unsigned DEPTH = `LBC_BUF_DEPTH
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  input wire logic drainAll,
  input wire logic outReady,
  output logic outValid,
  output logic [W-1:0] outData,
  output logic empty
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] HALF = (AW + 1)'(DEPTH / 2);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic outValid_reg, outValid_next;
  logic [W-1:0] outData_reg, outData_next;
  logic doWr, doRd;

  // Card writes wait until half a buffer is held, then go one word at a time, unless a flush is asked for
  always_comb begin
    doWr = inValid && (cnt_reg != FULL);
    doRd = (cnt_reg != '0) && (!outValid_reg || outReady) && (drainAll || cnt_reg >= HALF);
    wp_next = doWr ? wp_reg + 1'b1 : wp_reg;
    rp_next = doRd ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + (AW + 1)'(doWr) - (AW + 1)'(doRd);
    outData_next = doRd ? mem[rp_reg] : outData_reg;
    outValid_next = doRd || (outValid_reg && !outReady);
  end

  always_ff @(posedge sys_clk) begin
    if (doWr) begin
      mem[wp_reg] <= inData;
    end
    if (srst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      outValid_reg <= 1'b0;
      outData_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      outValid_reg <= outValid_next;
      outData_reg <= outData_next;
    end
  end

  assign outValid = outValid_reg;
  assign outData = outData_reg;
  assign empty = (cnt_reg == '0) && !outValid_reg;
endmodule : lbc_sample_buf
`default_nettype wire

// ---- rtl/lbc_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "lbc_defs.svh"
module lbc_top import lbc_pkg::*; #(
  parameter int unsigned SEC_CYC = `LBC_SEC_CYC,
  parameter int unsigned HOLD_CYC = `LBC_HOLD_CYC,
  parameter int unsigned FAST_HALF_CYC = `LBC_FAST_HALF_CYC,
  parameter int unsigned PULSE_CYC = `LBC_PULSE_CYC,
  parameter int unsigned DEB_CYC = `LBC_DEB_CYC,
  parameter int unsigned FW_REV = `LBC_FW_REV,
  parameter int unsigned BUF_DEPTH = `LBC_BUF_DEPTH,
  parameter int unsigned CW = `LBC_CNT_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic usbActivePin,
  input wire logic btnPin,
  input wire logic cardPresentPin,
  input wire logic usbXfer,
  input wire logic usbEnumDone,
  input wire logic [1:0] modeSel,
  input wire logic timeReached,
  input wire logic cardFull,
  input wire logic cardFormatted,
  input wire logic [15:0] cardMb,
  input wire logic sampleValid,
  input wire logic [`LBC_SAMPLE_W-1:0] sampleData,
  input wire logic cardWrReady,
  output logic ledOn,
  output logic sampleReq,
  output logic logActive,
  output logic cardWrValid,
  output logic [`LBC_SAMPLE_W-1:0] cardWrData,
  output logic mscEnable
);
  localparam logic [CW-1:0] SEC_LAST = CW'(SEC_CYC - 1);
  localparam logic [CW-1:0] HOLD_FIRE = CW'(HOLD_CYC - 1);
  localparam logic [CW-1:0] HOLD_SAT = CW'(HOLD_CYC);
  localparam logic [CW-1:0] FAST_LAST = CW'(FAST_HALF_CYC - 1);
  localparam logic [CW-1:0] PULSE_LEN = CW'(PULSE_CYC);

  logic [1:0] meta_reg, sync_reg;
  logic usbS, cardPresS, btnLevel, bufEmpty;
  lbc_state_t state_reg, state_next;
  lbc_mode_t mode;
  logic stIdle, stArmed, stLog, stFault, stFlush;
  logic [CW-1:0] secCnt_reg, secCnt_next, fastCnt_reg, fastCnt_next;
  logic [CW-1:0] holdCnt_reg, holdCnt_next, pulseCnt_reg, pulseCnt_next;
  logic [CW-1:0] sampCnt_reg, sampCnt_next;
  logic [2:0] initCnt_reg, initCnt_next;
  logic fastPh_reg, fastPh_next, stopped_reg, stopped_next;
  logic led_reg, led_next, sampReq_reg, sampReq_next, mscEn_reg;
  logic logAct_reg, logAct_next;
  logic secTick, fastWrap, holdEvent, pulseOn, cardOk, bufWr, usbLed;

  // Pins cross two flops; only the second flop is read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_reg <= 2'h0;
      sync_reg <= 2'h0;
    end else begin
      meta_reg <= {cardPresentPin, usbActivePin};
      sync_reg <= meta_reg;
    end
  end
  assign usbS = sync_reg[0];
  assign cardPresS = sync_reg[1];

  lbc_debounce #(.DEB_CYC(DEB_CYC), .CW(CW)) u_deb (
    .sys_clk(sys_clk),
    .srst(srst),
    .btnPin(btnPin),
    .btnLevel(btnLevel)
  );

  assign mode = lbc_mode_t'(modeSel);
  assign stIdle = (state_reg == ST_IDLE);
  assign stArmed = (state_reg == ST_ARMED);
  assign stLog = (state_reg == ST_LOG);
  assign stFault = (state_reg == ST_FAULT);
  assign stFlush = (state_reg == ST_FLUSH);

  // Timebases run free so blink pulses never depend on mode history
  always_comb begin
    secTick = (secCnt_reg == SEC_LAST);
    fastWrap = (fastCnt_reg == FAST_LAST);
    secCnt_next = secTick ? '0 : secCnt_reg + 1'b1;
    fastCnt_next = fastWrap ? '0 : fastCnt_reg + 1'b1;
    fastPh_next = fastWrap ? !fastPh_reg : fastPh_reg;
    holdEvent = btnLevel && (holdCnt_reg == HOLD_FIRE);
    if (!btnLevel) begin
      holdCnt_next = '0;
    end else if (holdCnt_reg != HOLD_SAT) begin
      holdCnt_next = holdCnt_reg + 1'b1;
    end else begin
      holdCnt_next = holdCnt_reg;
    end
    cardOk = cardPresS && cardFormatted && (cardMb <= `LBC_CARD_MAX_MB);
    bufWr = stLog && sampleValid;
    pulseOn = (pulseCnt_reg != '0);
    if (bufWr || (stArmed && secTick)) begin
      pulseCnt_next = PULSE_LEN;
    end else if (pulseOn) begin
      pulseCnt_next = pulseCnt_reg - 1'b1;
    end else begin
      pulseCnt_next = '0;
    end
    if (usbEnumDone) begin
      initCnt_next = `LBC_INIT_TOGGLES;
    end else if (fastWrap && initCnt_reg != 3'h0) begin
      initCnt_next = initCnt_reg - 1'b1;
    end else begin
      initCnt_next = initCnt_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    stopped_next = stopped_reg && !usbS;
    case (state_reg)
      ST_IDLE: begin
        if (!usbS && !stopped_reg && cardOk) begin
          case (mode)
            MODE_PWRUP: state_next = ST_LOG;
            MODE_BUTTON: state_next = holdEvent ? ST_LOG : ST_IDLE;
            MODE_TIMED: state_next = ST_ARMED;
            default: state_next = ST_IDLE;
          endcase
        end
      end
      ST_ARMED: begin
        if (usbS || mode != MODE_TIMED) begin
          state_next = ST_IDLE;
        end else if (holdEvent) begin
          state_next = ST_IDLE;
          stopped_next = 1'b1;
        end else if (timeReached) begin
          state_next = ST_LOG;
        end
      end
      ST_LOG: begin
        if (holdEvent || usbS) begin
          state_next = ST_FLUSH;
          stopped_next = 1'b1;
        end else if (!cardPresS || cardFull) begin
          state_next = ST_FAULT;
        end
      end
      ST_FAULT: begin
        if (holdEvent || usbS) begin
          state_next = ST_FLUSH;
          stopped_next = 1'b1;
        end else if (cardPresS && !cardFull) begin
          state_next = ST_LOG;
        end
      end
      ST_FLUSH: begin
        if (bufEmpty) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Sample clock restarts on entry so the first request lands a second later
  always_comb begin
    if (!stLog || state_next != ST_LOG) begin
      sampCnt_next = '0;
    end else if (sampCnt_reg == SEC_LAST) begin
      sampCnt_next = '0;
    end else begin
      sampCnt_next = sampCnt_reg + 1'b1;
    end
    sampReq_next = stLog && (state_next == ST_LOG) && (sampCnt_reg == SEC_LAST);
    // Own flop so the pin never carries a state decode glitch
    logAct_next = (state_next == ST_LOG);
    usbLed = (initCnt_reg != 3'h0 || usbXfer) ? fastPh_reg : 1'b1;
    case (state_reg)
      ST_LOG: led_next = !pulseOn;
      ST_ARMED: led_next = pulseOn;
      ST_FAULT: led_next = fastPh_reg;
      ST_FLUSH: led_next = 1'b0;
      ST_IDLE: led_next = usbS && usbLed;
      default: led_next = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      secCnt_reg <= '0;
      fastCnt_reg <= '0;
      fastPh_reg <= 1'b0;
      holdCnt_reg <= '0;
      pulseCnt_reg <= '0;
      sampCnt_reg <= '0;
      initCnt_reg <= 3'h0;
      stopped_reg <= 1'b0;
      led_reg <= 1'b0;
      sampReq_reg <= 1'b0;
      logAct_reg <= 1'b0;
      mscEn_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      secCnt_reg <= secCnt_next;
      fastCnt_reg <= fastCnt_next;
      fastPh_reg <= fastPh_next;
      holdCnt_reg <= holdCnt_next;
      pulseCnt_reg <= pulseCnt_next;
      sampCnt_reg <= sampCnt_next;
      initCnt_reg <= initCnt_next;
      stopped_reg <= stopped_next;
      led_reg <= led_next;
      sampReq_reg <= sampReq_next;
      logAct_reg <= logAct_next;
      mscEn_reg <= (FW_REV >= `LBC_MSC_MIN_REV);
    end
  end

  // Raw sample words go to the card unformatted by this block
  lbc_sample_buf #(.W(`LBC_SAMPLE_W), .DEPTH(BUF_DEPTH)) u_buf (
    .sys_clk(sys_clk),
    .srst(srst),
    .inValid(bufWr),
    .inData(sampleData),
    .drainAll(stFlush),
    .outReady(cardWrReady),
    .outValid(cardWrValid),
    .outData(cardWrData),
    .empty(bufEmpty)
  );

  assign ledOn = led_reg;
  assign sampleReq = sampReq_reg;
  assign logActive = logAct_reg;
  assign mscEnable = mscEn_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_dark;
    (stIdle && !usbS) |=> !ledOn;
  endproperty
  a_dark: assert property (p_dark) else $error("led lit with no usb and no log");
  property p_usb_on;
    (stIdle && usbS && initCnt_reg == 3'h0 && !usbXfer) |=> ledOn;
  endproperty
  a_usb_on: assert property (p_usb_on) else $error("led not steady on usb");
  property p_xfer;
    (stIdle && usbS && usbXfer) |=> (ledOn == $past(fastPh_reg));
  endproperty
  a_xfer: assert property (p_xfer) else $error("led not blinking in transfer");
  property p_off_mode;
    (stIdle && mode == MODE_OFF) |=> !logActive;
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("log started while disabled");
  property p_norec;
    (!stLog && sampleValid) |=> $stable(u_buf.cnt_reg) || $fell(u_buf.cnt_reg != '0) || !$past(bufEmpty);
  endproperty
  a_norec: assert property (p_norec) else $error("sample stored outside logging");
  property p_fault;
    stFault |=> (ledOn == $past(fastPh_reg));
  endproperty
  a_fault: assert property (p_fault) else $error("fault blink wrong");
  property p_first;
    (stLog && state_next == ST_LOG && sampCnt_reg == SEC_LAST) |=> sampleReq;
  endproperty
  a_first: assert property (p_first) else $error("sample request missed");
  property p_req_log;
    sampleReq |-> $past(stLog);
  endproperty
  a_req_log: assert property (p_req_log) else $error("sample request outside log");
  property p_stop;
    (stLog && holdEvent && !usbS) |=> (!logActive && stFlush) ##1 !ledOn;
  endproperty
  a_stop: assert property (p_stop) else $error("hold did not stop logging");
  property p_flush;
    (stFlush && !bufEmpty) |=> stFlush;
  endproperty
  a_flush: assert property (p_flush) else $error("left flush with data");
  property p_usb_ign;
    (stIdle && usbS) |=> !logActive;
  endproperty
  a_usb_ign: assert property (p_usb_ign) else $error("start while usb attached");
  property p_usb_stop;
    (stLog && usbS) |=> !logActive;
  endproperty
  a_usb_stop: assert property (p_usb_stop) else $error("logging kept on usb");
  property p_card;
    (stIdle && !cardOk) |=> !logActive;
  endproperty
  a_card: assert property (p_card) else $error("log with bad card");
  property p_release;
    !btnLevel |=> (holdCnt_reg == '0);
  endproperty
  a_release: assert property (p_release) else $error("hold count kept");

  property p_c_start;
    stIdle ##1 stLog;
  endproperty
  c_start: cover property (p_c_start);
  property p_c_fault;
    stFault ##1 stLog;
  endproperty
  c_fault: cover property (p_c_fault);
  property p_c_flush;
    stFlush ##1 stIdle;
  endproperty
  c_flush: cover property (p_c_flush);
  property p_c_timed;
    stArmed ##1 stLog;
  endproperty
  c_timed: cover property (p_c_timed);
endmodule : lbc_top
`default_nettype wire

// ---- verification/lbc_far_side.sv ----
`timescale 1ns/1ns
`default_nettype none
module lbc_far_side (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic stallEn,
  input wire logic logActive,
  input wire logic sampleReq,
  input wire logic cardWrValid,
  input wire logic [15:0] cardWrData,
  output logic sampleValid,
  output logic [15:0] sampleData,
  output logic cardWrReady
);
  logic [15:0] sentQ[$];
  logic [15:0] gotQ[$];
  logic [15:0] d;
  int waitCnt;
  always @(posedge sys_clk) begin
    if (srst) begin
      sentQ.delete();
      gotQ.delete();
      waitCnt <= 0;
      sampleValid <= 1'b0;
      sampleData <= 16'h0000;
      cardWrReady <= 1'b1;
    end else begin
      if (cardWrValid && cardWrReady) gotQ.push_back(cardWrData);
      // A word counts as recorded only if the block was logging as it came
      if (sampleValid && logActive) sentQ.push_back(sampleData);
      if (sampleReq) waitCnt <= 1 + $urandom % 3;
      else if (waitCnt > 0) waitCnt <= waitCnt - 1;
      // Idle data wanders so a stale word is never taken for a sample
      d = (waitCnt == 1) ? 16'($urandom) : ~sampleData;
      sampleData <= d;
      sampleValid <= (waitCnt == 1);
      cardWrReady <= stallEn ? 1'($urandom % 2) : 1'b1;
    end
  end
endmodule : lbc_far_side
`default_nettype wire

// ---- verification/tb_logging_led_button_control.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_logging_led_button_control import lbc_pkg::*;;
  localparam int SEC = 40;
  localparam int HOLD = 30;
  localparam int FH = 4;
  localparam int PU = 3;
  localparam int DEB = 2;
  logic sys_clk, srst, usbActivePin, btnPin, cardPresentPin, usbXfer, usbEnumDone;
  logic timeReached, cardFull, cardFormatted, sampleValid, cardWrReady, stallEn;
  logic [1:0] modeSel;
  logic [15:0] cardMb, sampleData, cardWrData;
  logic ledOn, sampleReq, logActive, cardWrValid, mscEnable, laPrev, ledPrev, reqSeen;
  int err_count, num_checks, cyc, tLa, tReq, runLen, lastHi, lastLo, togCnt, reqCnt;
  lbc_top #(.SEC_CYC(SEC), .HOLD_CYC(HOLD), .FAST_HALF_CYC(FH), .PULSE_CYC(PU),
    .DEB_CYC(DEB)) u_dut (.sys_clk(sys_clk), .srst(srst), .usbActivePin(usbActivePin),
    .btnPin(btnPin), .cardPresentPin(cardPresentPin), .usbXfer(usbXfer),
    .usbEnumDone(usbEnumDone), .modeSel(modeSel), .timeReached(timeReached),
    .cardFull(cardFull), .cardFormatted(cardFormatted), .cardMb(cardMb),
    .sampleValid(sampleValid), .sampleData(sampleData), .cardWrReady(cardWrReady),
    .ledOn(ledOn), .sampleReq(sampleReq), .logActive(logActive),
    .cardWrValid(cardWrValid), .cardWrData(cardWrData), .mscEnable(mscEnable));
  lbc_far_side u_far (.sys_clk(sys_clk), .srst(srst), .stallEn(stallEn),
    .logActive(logActive), .sampleReq(sampleReq), .cardWrValid(cardWrValid),
    .cardWrData(cardWrData), .sampleValid(sampleValid), .sampleData(sampleData),
    .cardWrReady(cardWrReady));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Run lengths of the indicator, sampled at the edge like the design sees them
  always @(posedge sys_clk) begin
    cyc++;
    if (logActive === 1'b1 && laPrev !== 1'b1) begin
      tLa = cyc;
      reqSeen = 1'b0;
    end
    if (sampleReq === 1'b1) begin
      reqCnt++;
      if (!reqSeen) tReq = cyc;
      reqSeen = 1'b1;
    end
    if (ledOn !== ledPrev) begin
      if (ledPrev === 1'b1) lastHi = runLen;
      else lastLo = runLen;
      runLen = 1;
      togCnt++;
    end else runLen++;
    laPrev = logActive;
    ledPrev = ledOn;
  end
  always @(posedge sys_clk) begin
    if (cyc == 8000) begin
      err_count++;
      final_report();
    end
  end
  task final_report;
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  function automatic logic exp_start(input logic [1:0] m, input logic f, input logic [15:0] mb);
    return m != MODE_OFF && f && mb <= 16'h0800;
  endfunction : exp_start
  task wt(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : wt
  task rst(input logic [1:0] m, input logic u, input logic f, input logic [15:0] mb);
    @(posedge sys_clk);
    srst <= 1'b1;
    modeSel <= m;
    usbActivePin <= u;
    cardFormatted <= f;
    cardMb <= mb;
    cardPresentPin <= 1'b1;
    cardFull <= 1'b0;
    timeReached <= 1'b0;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    wt(3);
  endtask : rst
  // Hold past sync, debounce and hold count, with a random overrun
  task hold_btn;
    @(posedge sys_clk);
    btnPin <= 1'b1;
    repeat (DEB + HOLD + 9 + $urandom % 4) @(posedge sys_clk);
    btnPin <= 1'b0;
    wt(4);
  endtask : hold_btn
  logic [1:0] tm[4] = '{MODE_BUTTON, MODE_BUTTON, MODE_BUTTON, MODE_OFF};
  logic tf[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic [15:0] tmb[4] = '{16'h0800, 16'h0801, 16'h0400, 16'h0200};
  initial begin
    {srst, usbActivePin, btnPin, usbXfer, usbEnumDone, timeReached, cardFull, stallEn} = '0;
    {cardPresentPin, cardFormatted} = 2'b11;
    modeSel = MODE_BUTTON;
    cardMb = 16'h0800;
    {err_count, num_checks, cyc, tLa, tReq, runLen, lastHi, lastLo, togCnt, reqCnt} = '0;
    {laPrev, ledPrev, reqSeen} = '0;
    void'($urandom(64));
    rst(MODE_BUTTON, 1'b0, 1'b1, 16'h0800);
    chk("mscEnable", 1, mscEnable);
    chk("ledOn idle", 0, ledOn);
    wt(5 * SEC);
    stallEn <= 1'b1;
    hold_btn();
    chk("logActive start", 1, logActive);
    chk("ledOn start", 1, ledOn);
    wt(3 * SEC);
    chk("first sample delay", 16'(SEC), 16'(tReq - tLa));
    chk("sample blink", 16'(PU), 16'(lastLo));
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      if (k == 0) cardPresentPin <= 1'b0;
      else cardFull <= 1'b1;
      wt(40);
      chk("fault logActive", 0, logActive);
      chk("fault hi run", 16'(FH), 16'(lastHi));
      chk("fault lo run", 16'(FH), 16'(lastLo));
      @(posedge sys_clk);
      cardPresentPin <= 1'b1;
      cardFull <= 1'b0;
      wt(10);
      chk("fault recover", 1, logActive);
    end
    wt(2 * SEC);
    hold_btn();
    chk("stop logActive", 0, logActive);
    chk("stop ledOn", 0, ledOn);
    wt(120);
    chk("samples sent", 1, 16'(u_far.sentQ.size() > 0));
    chk("words flushed", 16'(u_far.sentQ.size()), 16'(u_far.gotQ.size()));
    foreach (u_far.gotQ[i]) chk("card word", u_far.sentQ[i], u_far.gotQ[i]);
    rst(MODE_BUTTON, 1'b1, 1'b1, 16'h0400);
    wt(4);
    chk("usb steady", 1, ledOn);
    togCnt = 0;
    @(posedge sys_clk);
    usbEnumDone <= 1'b1;
    @(posedge sys_clk);
    usbEnumDone <= 1'b0;
    wt(8 * FH + 10);
    chk("enum blinks", 16'h0006, 16'(togCnt));
    chk("enum then lit", 1, ledOn);
    @(posedge sys_clk);
    usbXfer <= 1'b1;
    wt(30);
    chk("xfer blink", 16'(FH), 16'(lastHi));
    @(posedge sys_clk);
    usbXfer <= 1'b0;
    wt(3 * SEC);
    hold_btn();
    chk("usb button", 0, logActive);
    chk("usb button led", 1, ledOn);
    rst(MODE_PWRUP, 1'b1, 1'b1, 16'h0400);
    wt(10);
    chk("usb pwrup", 0, logActive);
    for (int k = 0; k < 4; k++) begin
      rst(tm[k], 1'b0, tf[k], tmb[k]);
      wt(5 * SEC);
      reqCnt = 0;
      hold_btn();
      chk("start gate", 16'(exp_start(tm[k], tf[k], tmb[k])), logActive);
      if (tm[k] == MODE_OFF) begin
        wt(2 * SEC);
        chk("off led", 0, ledOn);
        chk("off samples", 0, 16'(reqCnt));
      end
    end
    rst(MODE_PWRUP, 1'b0, 1'b1, 16'h0400);
    wt(4);
    chk("pwrup log", 1, logActive);
    chk("pwrup led", 1, ledOn);
    wt(2 * SEC);
    chk("pwrup blink", 16'(PU), 16'(lastLo));
    rst(MODE_TIMED, 1'b0, 1'b1, 16'h0400);
    wt(3 * SEC);
    chk("timed wait", 0, logActive);
    chk("timed flash", 16'(PU), 16'(lastHi));
    chk("timed gap", 16'(SEC - PU), 16'(lastLo));
    @(posedge sys_clk);
    timeReached <= 1'b1;
    wt(4);
    chk("timed start", 1, logActive);
    final_report();
  end
endmodule : tb_logging_led_button_control
`default_nettype wire
